// ---- verilog/pcsr_cfg.svh ----
// Address map, bit positions, reset values and clock figures of the block
`ifndef PCSR_CFG_SVH
`define PCSR_CFG_SVH

// Register offsets
`define PCSR_ADDR_CTRL      8'h01
`define PCSR_ADDR_SLEEP     8'h02
`define PCSR_ADDR_STAT      8'h03

// Control register fields
`define PCSR_CTRL_SLEEP_PERMIT 7
`define PCSR_CTRL_AUX_EN       6
`define PCSR_CTRL_CONV2_EN     5
`define PCSR_CTRL_EXT_CLOCK_PIN_EN      4
`define PCSR_CTRL_EXT_CLOCK_PIN_FREQ    3
`define PCSR_CTRL_RESET        8'h70
`define PCSR_CTRL_MASK         8'hF8

// Sleep request register fields
`define PCSR_SLEEP_REQ_BIT     7
`define PCSR_SLEEP_RESET       8'h00
`define PCSR_SLEEP_MASK        8'h80

// Status register fields, bit 7 down to bit 0
`define PCSR_STAT_PRIOR_SLEEP  7
`define PCSR_STAT_AUX_OK       6
`define PCSR_STAT_SUPPLY2_OK   5
`define PCSR_STAT_BUS_OK       4
`define PCSR_STAT_FILT_OK      3
`define PCSR_STAT_XTAL_RUN     2
`define PCSR_STAT_THERM_WARN   1
`define PCSR_STAT_PRIOR_TSD    0
`define PCSR_STAT_RESET        8'h00

// Clock figures in Hz
`define PCSR_SYS_CLK_HZ        100000000
`define PCSR_EXT_CLOCK_PIN_LO_HZ        8000000
`define PCSR_EXT_CLOCK_PIN_HI_HZ        16000000

// Answer to an unmapped read
`define PCSR_RDATA_IDLE        8'h00

`endif

// ---- verilog/pcsr_pkg.sv ----
// Types shared by the power, clock and sleep register block
package pcsr_pkg;

  // One register byte
  typedef logic [7:0] pcsr_byte_t;

  // Sleep state, Gray coded
  typedef enum logic [1:0] {
    PCSR_AWAKE  = 2'h0,
    PCSR_ASLEEP = 2'h1
  } pcsr_state_t;

endpackage

// ---- verilog/pcsr_clk_if.sv ----
// Link between the register bank and the external clock generator
`timescale 1ns/1ns
interface pcsr_clk_if;
  logic enable;    // Clock output gate
  logic freq_hi;   // High: fast rate, low: slow rate
  logic clk_out;   // Generated clock level

  // Register side
  modport ctl (output enable, output freq_hi, input clk_out);
  // Generator side
  modport gen (input enable, input freq_hi, output clk_out);
endinterface

// ---- verilog/pcsr_sync.sv ----
// Two-stage synchronizer for a group of level inputs
`timescale 1ns/1ns
module pcsr_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // Levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] stage1;        // Only read by stage two
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  // Next values of both stages
  always_comb begin
    next_stage1 = i_d;
    next_q      = stage1;
  end

  // Registers, cleared at reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= '0;
      o_q    <= '0;
    end else begin
      stage1 <= next_stage1;
      o_q    <= next_q;
    end
  end
endmodule // pcsr_sync

// ---- verilog/pcsr_clkgen.sv ----
// Phase accumulator that makes the gated external clock
`timescale 1ns/1ns
`include "pcsr_cfg.svh"
module pcsr_clkgen #(
  parameter int ACC_W = 16
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // Control and clock level
  pcsr_clk_if.gen   clk_bus
);
  // Step per cycle, rounded down: mean rate runs low by less than one 2^ACC_W-th of the system clock
  localparam longint STEP_LO_L = (longint'(`PCSR_EXT_CLOCK_PIN_LO_HZ) << ACC_W) / `PCSR_SYS_CLK_HZ;
  localparam longint STEP_HI_L = (longint'(`PCSR_EXT_CLOCK_PIN_HI_HZ) << ACC_W) / `PCSR_SYS_CLK_HZ;
  localparam logic [ACC_W-1:0] STEP_LO = STEP_LO_L[ACC_W-1:0];
  localparam logic [ACC_W-1:0] STEP_HI = STEP_HI_L[ACC_W-1:0];

  logic [ACC_W-1:0] acc;        // Phase
  logic [ACC_W-1:0] next_acc;
  logic             clk_q;      // Registered clock level
  logic             next_clk_q;

  // Advance phase only while enabled; jitter is one system period
  always_comb begin
    next_acc   = acc;
    next_clk_q = 1'b0;
    if (clk_bus.enable) begin
      next_acc   = acc + (clk_bus.freq_hi ? STEP_HI : STEP_LO);
      next_clk_q = acc[ACC_W-1];
    end
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc   <= '0;
      clk_q <= 1'b0;
    end else begin
      acc   <= next_acc;
      clk_q <= next_clk_q;
    end
  end

  assign clk_bus.clk_out = clk_q;
endmodule // pcsr_clkgen

// ---- verilog/pcsr_regs.sv ----
// Power, clock and sleep register bank with its sleep state
//
// What this block does
// RULE1 - Control register at 0x01, resets to 0x70
// RULE2 - Bit 7 permits sleep, resets to zero
// RULE3 - Sleep permit alone never starts sleep
// RULE4 - Bit 6 switches auxiliary regulator, resets on
// RULE5 - Bit 5 switches second converter, resets on
// RULE6 - Bit 4 gates external clock, resets on
// RULE7 - Bit 3 picks 8 or 16 MHz
// RULE8 - Control bits 0 to 2 do nothing
// RULE9 - Sleep request register at 0x02, resets zero
// RULE10 - Request bit with permit enters sleep
// RULE11 - Only a wake event ends sleep
// RULE12 - Sleep request bits 0 to 6 do nothing
// RULE13 - Read-only status at 0x03, resets zero
// RULE14 - Status bit order fixed, bit 7 down
// RULE15 - Supply bits read one when above threshold
// RULE16 - Crystal and warning bits follow live state
// RULE17 - Prior sleep and shutdown are remembered
// RULE18 - Monitor inputs pass a two-stage synchronizer
// RULE19 - Reserved bits read back as zero
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "pcsr_cfg.svh"
module pcsr_regs #(
  parameter int ADDR_W = 8,
  parameter int ACC_W  = 16
) (
  // Clock and reset
  input  wire logic               I_SYS_CLK,
  input  wire logic               I_ARST_N,
  // Register port
  input  wire logic [ADDR_W-1:0]  I_ADDR,
  input  wire pcsr_pkg::pcsr_byte_t I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output pcsr_pkg::pcsr_byte_t    O_RDATA,
  // Monitor levels, high means good or active
  input  wire logic               I_AUX_REG_GOOD,
  input  wire logic               I_SUPPLY2_GOOD,
  input  wire logic               I_BUS_GOOD,
  input  wire logic               I_FILT_GOOD,
  input  wire logic               I_XTAL_RUN,
  input  wire logic               I_THERM_WARN,
  input  wire logic               I_THERM_SHUTDOWN,
  // Wake pin level
  input  wire logic               I_WAKE_INPUT_PIN,
  // Power and clock controls
  output logic                    O_AUX_REG_EN,
  output logic                    O_CONV2_EN,
  output logic                    O_EXT_CLOCK_PIN,
  output logic                    O_SLEEP
);
  import pcsr_pkg::*;

  // Register map and behaviour in brief:
  //   0x01 power and clock control; bits 2:0 are stored as zero
  //   0x02 sleep request; bits 6:0 are stored as zero
  //   0x03 status; read only, writes fall through unused
  //   other addresses read as zero and ignore writes
  // Read data stands for exactly one cycle after the read strobe and
  // is zero otherwise, so a host may sample it without a valid flag.
  // Sleep needs two separate writes: the permit first, then the request.
  // A request in the same cycle as the permit write does not count,
  // which keeps a single stray write from putting the device to sleep.
  // Limitation: wake is the rising edge of the synchronised pin, so a
  // pin held high while going to sleep must drop and rise again.
  // Trade-off: the monitors lag the pins by two cycles, which is far
  // below any supply or thermal time constant, and buys a clean edge
  // for the sticky bits and the wake detector.

  localparam int MON_W = 8;  // Seven monitors plus wake pin

  // Reset levels of the power outputs, taken from the control reset byte
  localparam pcsr_byte_t CTRL_RST = `PCSR_CTRL_RESET;
  localparam logic       AUX_RST  = CTRL_RST[`PCSR_CTRL_AUX_EN];
  localparam logic       CONV_RST = CTRL_RST[`PCSR_CTRL_CONV2_EN];

  // Address decode, used by both the write and the read path
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] reg_addr);
    hit = (a == ADDR_W'(reg_addr));
  endfunction

  // Register state
  pcsr_byte_t  ctrl;           // Power and clock control
  pcsr_byte_t  next_ctrl;
  pcsr_byte_t  sleep_req;      // Sleep request
  pcsr_byte_t  next_sleep_req;
  pcsr_state_t state;          // Awake or asleep
  pcsr_state_t next_state;
  logic        prior_sleep;    // Sticky: woke from sleep
  logic        next_prior_sleep;
  logic        prior_tsd;      // Sticky: shutdown seen
  logic        next_prior_tsd;
  logic        wake_last;      // Wake level one cycle ago
  logic        next_wake_last;
  pcsr_byte_t  rdata;          // Read answer register
  pcsr_byte_t  next_rdata;
  logic        aux_en;         // Registered regulator enable
  logic        next_aux_en;
  logic        conv2_en;       // Registered converter enable
  logic        next_conv2_en;
  logic        sleep_out;      // Registered sleep level
  logic        next_sleep_out;

  // Monitors after the synchronizer
  logic [MON_W-1:0] mon_raw;
  logic [MON_W-1:0] mon_sync;
  logic             aux_ok;
  logic             supply2_ok;
  logic             bus_ok;
  logic             filt_ok;
  logic             xtal_run;
  logic             therm_warn;
  logic             therm_sd;
  logic             wake_lvl;

  // Decoded strobes
  logic       wr_ctrl;
  logic       wr_sleep;
  logic       rd_stat;
  logic       wake_event;
  logic       sleep_go;
  pcsr_byte_t status;

  pcsr_clk_if clk_link ();

  // All monitor inputs and the wake pin cross into the clock domain
  // Order matches the slices below; the wake pin sits on top
  assign mon_raw = {I_WAKE_INPUT_PIN, I_THERM_SHUTDOWN, I_THERM_WARN,
                    I_XTAL_RUN, I_FILT_GOOD, I_BUS_GOOD,
                    I_SUPPLY2_GOOD, I_AUX_REG_GOOD};

  // Two flops per level before any use
  // The monitors are slow analog comparators; two flops bound the chance
  // of a metastable level reaching the sticky bits or the wake edge
  pcsr_sync #(
    .W (MON_W)
  ) u_sync (
    .i_clk    (I_SYS_CLK),
    .i_arst_n (I_ARST_N),
    .i_d      (mon_raw),
    .o_q      (mon_sync)
  ); // RULE18

  assign aux_ok     = mon_sync[0];
  assign supply2_ok = mon_sync[1];
  assign bus_ok     = mon_sync[2];
  assign filt_ok    = mon_sync[3];
  assign xtal_run   = mon_sync[4];
  assign therm_warn = mon_sync[5];
  assign therm_sd   = mon_sync[6];
  assign wake_lvl   = mon_sync[7];

  // Strobes: writes to the status address fall through unused
  // All three strobes decode through the same function, which keeps the
  // write and read maps from drifting apart
  assign wr_ctrl  = I_WR && hit(I_ADDR, `PCSR_ADDR_CTRL);
  assign wr_sleep = I_WR && hit(I_ADDR, `PCSR_ADDR_SLEEP);
  assign rd_stat  = I_RD && hit(I_ADDR, `PCSR_ADDR_STAT); // RULE13

  // Rising edge of the synced wake level; reads only the second stage
  // The edge register resets low, matching a wake pin that idles low
  assign wake_event = wake_lvl && !wake_last;

  // Sleep starts only on a request write while permit is already set
  // Permit is the stored bit, not the data of a write in the same cycle
  assign sleep_go = wr_sleep && I_WDATA[`PCSR_SLEEP_REQ_BIT]
                    && ctrl[`PCSR_CTRL_SLEEP_PERMIT]; // RULE10 RULE3 RULE2

  // Status byte assembled in fixed order
  // Live bits follow the synced monitors; only bits 7 and 0 hold history
  always_comb begin
    status = `PCSR_STAT_RESET;
    status[`PCSR_STAT_PRIOR_SLEEP] = prior_sleep;  // RULE17
    status[`PCSR_STAT_AUX_OK]      = aux_ok;       // RULE15
    status[`PCSR_STAT_SUPPLY2_OK]  = supply2_ok;   // RULE15
    status[`PCSR_STAT_BUS_OK]      = bus_ok;       // RULE15
    status[`PCSR_STAT_FILT_OK]     = filt_ok;      // RULE15
    status[`PCSR_STAT_XTAL_RUN]    = xtal_run;     // RULE16
    status[`PCSR_STAT_THERM_WARN]  = therm_warn;   // RULE16
    status[`PCSR_STAT_PRIOR_TSD]   = prior_tsd;    // RULE17 RULE14
  end

  // Control and request registers, reserved bits masked on store
  // Masking on the way in means reads need no mask of their own
  always_comb begin
    next_ctrl      = ctrl;
    next_sleep_req = sleep_req;
    if (wr_ctrl) begin
      next_ctrl = I_WDATA & `PCSR_CTRL_MASK; // RULE8 RULE19
    end
    if (wr_sleep) begin
      next_sleep_req = I_WDATA & `PCSR_SLEEP_MASK; // RULE12 RULE19
    end
  end

  // Control and request storage
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl      <= `PCSR_CTRL_RESET;  // RULE1 RULE2 RULE4 RULE5 RULE6 RULE7
      sleep_req <= `PCSR_SLEEP_RESET; // RULE9
    end else begin
      ctrl      <= next_ctrl;
      sleep_req <= next_sleep_req;
    end
  end

  // Sleep state: no register write can leave the asleep state.
  // Requests while asleep are ignored; the stored request byte keeps
  // whatever was written and is not cleared on wake, so software must
  // rewrite it before the next sleep.
  always_comb begin
    next_state     = state;
    next_wake_last = wake_lvl;
    unique case (state)
      PCSR_AWAKE: begin
        if (sleep_go) begin
          next_state = PCSR_ASLEEP; // RULE10
        end
      end
      PCSR_ASLEEP: begin
        if (wake_event) begin
          next_state = PCSR_AWAKE; // RULE11
        end
      end
      default: begin
        next_state = PCSR_AWAKE;  // Two codes unused
      end
    endcase
  end

  // Sleep state storage
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state     <= PCSR_AWAKE;
      wake_last <= 1'b0;
    end else begin
      state     <= next_state;
      wake_last <= next_wake_last;
    end
  end

  // Sticky history bits: cleared by a status read, a new event wins
  // The read returns the old value, since the answer register samples
  // status in the same cycle as the clear; the set is applied after the
  // clear so an event in that cycle is not lost.
  always_comb begin
    next_prior_sleep = prior_sleep;
    next_prior_tsd   = prior_tsd;
    if (rd_stat) begin
      next_prior_sleep = 1'b0;
      next_prior_tsd   = 1'b0;
    end
    if (state == PCSR_ASLEEP && wake_event) begin
      next_prior_sleep = 1'b1; // RULE17
    end
    if (therm_sd) begin
      next_prior_tsd = 1'b1;   // RULE17
    end
  end

  // History storage
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      prior_sleep <= 1'b0;
      prior_tsd   <= 1'b0;
    end else begin
      prior_sleep <= next_prior_sleep;
      prior_tsd   <= next_prior_tsd;
    end
  end

  // Read answer, valid the cycle after the strobe only
  // Unmapped addresses and idle cycles answer zero, so the data lines
  // never show stale register contents to a host that samples late
  always_comb begin
    next_rdata = `PCSR_RDATA_IDLE;
    if (I_RD) begin
      if (hit(I_ADDR, `PCSR_ADDR_CTRL)) begin
        next_rdata = ctrl;
      end else if (hit(I_ADDR, `PCSR_ADDR_SLEEP)) begin
        next_rdata = sleep_req;
      end else if (hit(I_ADDR, `PCSR_ADDR_STAT)) begin
        next_rdata = status; // RULE13 RULE14
      end
    end
  end

  // Read answer storage
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata <= `PCSR_RDATA_IDLE;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Power outputs follow the control bits one cycle later
  // The extra flop keeps the pins glitch free across control writes
  always_comb begin
    next_aux_en    = ctrl[`PCSR_CTRL_AUX_EN];   // RULE4
    next_conv2_en  = ctrl[`PCSR_CTRL_CONV2_EN]; // RULE5
    next_sleep_out = (next_state == PCSR_ASLEEP);
  end

  // Output flops; the enables reset to the control reset levels, the sleep level resets low
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aux_en    <= AUX_RST;
      conv2_en  <= CONV_RST;
      sleep_out <= 1'b0;
    end else begin
      aux_en    <= next_aux_en;
      conv2_en  <= next_conv2_en;
      sleep_out <= next_sleep_out;
    end
  end

  // External clock gate and rate
  // Gate and rate come straight from the stored control bits
  assign clk_link.enable  = ctrl[`PCSR_CTRL_EXT_CLOCK_PIN_EN];   // RULE6
  assign clk_link.freq_hi = ctrl[`PCSR_CTRL_EXT_CLOCK_PIN_FREQ]; // RULE7

  // Clock generator; its output is already a flop
  // The rate is a mean: edges jitter by one system period, which a
  // consumer of the clock must tolerate. Disabling parks the output
  // low and freezes the phase.
  pcsr_clkgen #(
    .ACC_W (ACC_W)
  ) u_clkgen (
    .i_clk    (I_SYS_CLK),
    .i_arst_n (I_ARST_N),
    .clk_bus  (clk_link)
  );

  // Every top output comes straight from a flop, so no glitch from the
  // decode logic reaches a pin
  assign O_RDATA         = rdata;
  assign O_AUX_REG_EN    = aux_en;
  assign O_CONV2_EN      = conv2_en;
  assign O_EXT_CLOCK_PIN = clk_link.clk_out;
  assign O_SLEEP         = sleep_out;
endmodule // pcsr_regs

// ---- bench/pcsr_regs_sva.sv ----
// Concurrent checks on the port behaviour of the power, clock and sleep register bank
`timescale 1ns/1ns
module pcsr_regs_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic                 I_SYS_CLK,
  input wire logic                 I_ARST_N,
  // Register port
  input wire logic [ADDR_W-1:0]    I_ADDR,
  input wire pcsr_pkg::pcsr_byte_t I_WDATA,
  input wire logic                 I_WR,
  input wire logic                 I_RD,
  input wire pcsr_pkg::pcsr_byte_t O_RDATA,
  // Wake pin and controls
  input wire logic                 I_WAKE_INPUT_PIN,
  input wire logic                 O_AUX_REG_EN,
  input wire logic                 O_EXT_CLOCK_PIN,
  input wire logic                 O_SLEEP
);
  import pcsr_pkg::*;
  logic permit;  // Mirror of the stored sleep permit
  logic xen;     // Mirror of the stored clock gate
  logic req;     // A sleep request write this cycle
  assign req = I_WR && I_ADDR == 'h02 && I_WDATA[7];
  // Mirrors follow control writes; they must lag so a same-edge permit does not count
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      permit <= 1'b0;
      xen    <= 1'b1;
    end else if (I_WR && I_ADDR == 'h01) begin
      permit <= I_WDATA[7];
      xen    <= I_WDATA[4];
    end
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  chk_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (I_RD && !(I_ADDR inside {'h01, 'h02, 'h03})
    |=> O_RDATA == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_reserved: assert property (I_RD && I_ADDR == 'h01 |=> O_RDATA[2:0] == 3'h0)
    else $error("control reserved bits not zero");
  chk_sleep_reserved: assert property (I_RD && I_ADDR == 'h02 |=> O_RDATA[6:0] == 7'h00)
    else $error("sleep reserved bits not zero");
  chk_sleep_entry: assert property (req && permit |=> O_SLEEP)
    else $error("sleep not entered");
  chk_no_sleep: assert property (!O_SLEEP && !(req && permit) |=> !O_SLEEP)
    else $error("sleep entered without request");
  chk_sleep_hold: assert property (O_SLEEP && !$past(I_WAKE_INPUT_PIN)
    && !$past(I_WAKE_INPUT_PIN, 2) && !$past(I_WAKE_INPUT_PIN, 3) |=> O_SLEEP)
    else $error("sleep left without wake");
  chk_wake_exit: assert property (O_SLEEP && $rose(I_WAKE_INPUT_PIN) |-> ##[1:4] !O_SLEEP)
    else $error("wake did not end sleep");
  chk_aux_follow: assert property (I_WR && I_ADDR == 'h01
    |-> ##2 O_AUX_REG_EN == $past(I_WDATA[6], 2)) else $error("regulator enable wrong");
  chk_clk_gated: assert property (!xen && !$past(xen) && !$past(xen, 2) |-> !O_EXT_CLOCK_PIN)
    else $error("clock output not gated");
endmodule // pcsr_regs_sva

// ---- bench/pcsr_host_model.sv ----
// Host controller model that issues single register cycles
`timescale 1ns/1ns
module pcsr_host_model (
  // Clock
  input  wire logic                 i_clk,
  // Register port
  output logic [7:0]                o_addr,
  output pcsr_pkg::pcsr_byte_t      o_wdata,
  output logic                      o_wr,
  output logic                      o_rd,
  input  wire pcsr_pkg::pcsr_byte_t i_rdata
);
  import pcsr_pkg::*;
  // Idle lines carry inverted values so a stale address is never mistaken for valid
  initial begin
    o_addr  = 8'hFF;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // One write cycle
  task automatic wr(input logic [7:0] a, input pcsr_byte_t d);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  // One read cycle; data is taken in the single cycle it stands
  task automatic rd(input logic [7:0] a, output pcsr_byte_t d);
    @(posedge i_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule // pcsr_host_model

// ---- bench/power_clock_sleep_regs_test.sv ----
// Self-checking bench for the power, clock and sleep register bank
`timescale 1ns/1ns
module power_clock_sleep_regs_test;
  import pcsr_pkg::*;
  logic       clk;     // System clock
  logic       arst_n;  // Reset
  logic [7:0] addr;    // Register address
  pcsr_byte_t wdata;   // Write data
  logic       wr;      // Write strobe
  logic       rd;      // Read strobe
  pcsr_byte_t rdata;   // Read data
  logic [7:0] mon;     // Monitor levels in status bit order
  logic       wake;    // Wake pin
  logic       aux;     // Regulator enable
  logic       conv2;   // Converter enable
  logic       ext_clock_pin;    // External clock
  logic       sleep_request_bit;     // Asleep
  int         err_total;
  int         n_checks;
  int         n;
  pcsr_byte_t pats[3] = '{8'h7E, 8'h54, 8'h2A};
  pcsr_regs dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_AUX_REG_GOOD(mon[6]), .I_SUPPLY2_GOOD(mon[5]),
    .I_BUS_GOOD(mon[4]), .I_FILT_GOOD(mon[3]), .I_XTAL_RUN(mon[2]), .I_THERM_WARN(mon[1]),
    .I_THERM_SHUTDOWN(mon[0]), .I_WAKE_INPUT_PIN(wake), .O_AUX_REG_EN(aux),
    .O_CONV2_EN(conv2), .O_EXT_CLOCK_PIN(ext_clock_pin), .O_SLEEP(sleep_request_bit));
  pcsr_host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read one register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    pcsr_byte_t d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  // Rising edges of the external clock over a number of cycles
  task automatic count_clk(input int ncyc, output int cnt);
    logic last;
    cnt = 0;
    last = ext_clock_pin;
    repeat (ncyc) begin
      @(posedge clk);
      #1;
      if (ext_clock_pin === 1'b1 && last === 1'b0) begin
        cnt++;
      end
      last = ext_clock_pin;
    end
  endtask
  // Verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the roughly 700 cycles the tests take
  initial begin
    #200000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  // Test sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    arst_n = 1'b0;
    mon = 8'h00;
    wake = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk({6'h0, aux, conv2}, 8'h03);
    rdchk(8'h01, 8'h70);
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, 8'h00);
    $display("reset test done");
    host.wr(8'h01, 8'hFF);
    rdchk(8'h01, 8'hF8);
    host.wr(8'h01, 8'h07);
    rdchk(8'h01, 8'h00);
    chk({6'h0, aux, conv2}, 8'h00);
    count_clk(200, n);
    chk(8'(n), 8'h00);
    host.wr(8'h01, 8'h50);
    count_clk(200, n);
    chk(8'(n >= 15 && n <= 17), 8'h01);
    chk({6'h0, aux, conv2}, 8'h02);
    host.wr(8'h01, 8'h18);
    count_clk(200, n);
    chk(8'(n >= 31 && n <= 33), 8'h01);
    $display("control test done");
    foreach (pats[i]) begin
      @(posedge clk);
      mon <= pats[i];
      repeat (3) @(posedge clk);
      rdchk(8'h03, pats[i] & 8'h7E);
      host.wr(8'h03, 8'hFF);
      rdchk(8'h03, pats[i] & 8'h7E);
    end
    rdchk(8'h00, 8'h00);
    rdchk(8'hFF, 8'h00);
    $display("status test done");
    @(posedge clk);
    mon <= 8'h00;
    host.wr(8'h01, 8'h70);
    host.wr(8'h02, 8'h80);
    repeat (3) @(posedge clk);
    chk({7'h0, sleep_request_bit}, 8'h00);
    rdchk(8'h02, 8'h80);
    host.wr(8'h02, 8'h7F);
    rdchk(8'h02, 8'h00);
    host.wr(8'h01, 8'hF0);
    repeat (4) @(posedge clk);
    chk({7'h0, sleep_request_bit}, 8'h00);
    host.wr(8'h02, 8'h80);
    #1;
    chk({7'h0, sleep_request_bit}, 8'h01);
    host.wr(8'h01, 8'h00);
    host.wr(8'h02, 8'h00);
    repeat (10) @(posedge clk);
    chk({7'h0, sleep_request_bit}, 8'h01);
    wake <= 1'b1;
    repeat (5) @(posedge clk);
    wake <= 1'b0;
    #1;
    chk({7'h0, sleep_request_bit}, 8'h00);
    rdchk(8'h03, 8'h80);
    rdchk(8'h03, 8'h00);
    @(posedge clk);
    mon <= 8'h01;
    repeat (3) @(posedge clk);
    mon <= 8'h00;
    repeat (3) @(posedge clk);
    rdchk(8'h03, 8'h01);
    rdchk(8'h03, 8'h00);
    $display("sleep test done");
    finish_test();
  end
endmodule // power_clock_sleep_regs_test

bind pcsr_regs pcsr_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.I_SYS_CLK, .I_ARST_N, .I_ADDR,
  .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_WAKE_INPUT_PIN, .O_AUX_REG_EN, .O_EXT_CLOCK_PIN,
  .O_SLEEP);
